// ### hdl/frame_state_vector_check_encoder.sv
/*
 * Frame tail encoder: attaches the optional state code to the data
 * field and closes the frame with a 3-bit CRC or an even parity bit.
 * Assumes frame pacing, start bits and line coding sit outside, and
 * that the caller drives requests synchronous to MCLK.
 */
`timescale 1ns/100ps
`include "fsvce_cfg.svh"

module frame_state_vector_check_encoder #(
    // error type sent for a configuration error; value is arbitrary
    parameter logic [`DATA_W-1:0] CONFIG_ERROR_CODE = 10'h001
) (
    // clock and reset
    input  wire logic                   MCLK,
    input  wire logic                   RST,
    // configuration bits
    input  wire logic                   STATE_CODE_DISABLE,
    input  wire logic                   CHECK_METHOD_SELECT,
    input  wire logic                   DATA_WIDTH_SELECT,
    input  wire logic                   OFFSET_REMOVAL_ENABLE,
    input  wire logic                   DEVICE_DATA_MODE_HIGH,
    input  wire logic                   DEVICE_DATA_MODE_LOW,
    // device status
    input  wire logic                   CONFIG_MODE,
    input  wire logic                   SELF_TEST_DRIVE,
    // frame request
    input  wire logic                   FRAME_REQ,
    input  wire logic [`KIND_W-1:0]     FRAME_KIND,
    input  wire logic [`DATA_W-1:0]     FRAME_DATA,
    // finished frame
    output logic                        FRAME_VALID,
    output logic [`FRAME_W-1:0]         FRAME_BITS,
    output logic [`LEN_W-1:0]           FRAME_LEN,
    output logic                        STATE_CODE_BIT_HIGH,
    output logic                        STATE_CODE_BIT_MID,
    output logic                        STATE_CODE_BIT_LOW,
    // status
    output logic                        BUSY,
    output logic                        REJECT,
    output logic                        FULL_RANGE,
    output logic                        CONFIG_ERROR
);

    // ************************************************************
    // declarations
    // ************************************************************
    frame_enc_pkg::enc_state_e state_q;
    frame_enc_pkg::enc_state_e state_d;

    frame_enc_pkg::content_t   content_q;
    frame_enc_pkg::content_t   content_w;
    frame_enc_pkg::frame_t     frame_q;
    frame_enc_pkg::frame_t     frame_w;
    frame_enc_pkg::data_t      field_w;
    frame_enc_pkg::data_t      device_field_w;
    frame_enc_pkg::data_t      run_field_w;

    logic [`CNT_W-1:0]         cnt_q;
    logic [`CNT_W-1:0]         content_len_w;
    logic [`CNT_W-1:0]         sc_len_w;
    logic [`CNT_W-1:0]         data_len_w;
    logic [`LEN_W-1:0]         check_len_w;
    logic [`LEN_W-1:0]         frame_len_w;
    logic [`LEN_W-1:0]         len_q;
    logic [`SC_W-1:0]          sc_w;
    logic [`SC_W-1:0]          sc_q;
    logic [`CRC_W-1:0]         crc_rem;
    logic [1:0]                mode_w;
    logic [`CONTENT_W-1:0]     code_shift_w;
    logic [`CONTENT_W-1:0]     field_ext_w;

    logic                      idle_w;
    logic                      kind_ok_w;
    logic                      take_w;
    logic                      reject_w;
    logic                      run_cfg_err_w;
    logic                      width_cfg_err_w;
    logic                      cfg_err_w;
    logic                      full_range_w;
    logic                      shift_w;
    logic                      last_bit_w;
    logic                      parity_w;

    logic                      omit_sc_q;
    logic                      parity_mode_q;
    logic                      valid_q;
    logic                      reject_q;
    logic                      busy_q;
    logic                      full_range_q;
    logic                      cfg_err_q;

    // ************************************************************
    // request acceptance
    // ************************************************************
    assign mode_w  = {DEVICE_DATA_MODE_HIGH, DEVICE_DATA_MODE_LOW};
    assign idle_w  = (state_q == frame_enc_pkg::ST_IDLE);

    // memory frames only in configuration mode
    assign kind_ok_w = (FRAME_KIND == `KIND_RUN)
                    || (FRAME_KIND == `KIND_DEVICE)
                    || (FRAME_KIND == `KIND_SELFTEST)
                    || (FRAME_KIND == `KIND_AUTOZERO)
                    || (FRAME_KIND == `KIND_ERROR)
                    || ((FRAME_KIND == `KIND_OTP) && CONFIG_MODE);

    // a request while busy is dropped rather than queued, so the
    // caller must pace frames; the reject pulse makes it visible
    assign take_w   = FRAME_REQ && idle_w && kind_ok_w;
    assign reject_w = FRAME_REQ && !(idle_w && kind_ok_w);

    // mode 0 needs the state code to tag its messages
    assign run_cfg_err_w   = STATE_CODE_DISABLE && (mode_w == `MODE_ALL);
    // 10-bit device data cannot fit an 8-bit field
    assign width_cfg_err_w = DATA_WIDTH_SELECT && (mode_w == `MODE_10BIT);
    assign cfg_err_w       = run_cfg_err_w || width_cfg_err_w;

    // full range only with both bits clear
    assign full_range_w = !STATE_CODE_DISABLE && !OFFSET_REMOVAL_ENABLE;

    // ************************************************************
    // state code selection
    // ************************************************************
    always_comb begin
        sc_w = `SC_RUN;
        case (FRAME_KIND)
            `KIND_RUN:      sc_w = cfg_err_w ? `SC_ERROR : `SC_RUN;
            `KIND_DEVICE:   sc_w = `SC_DEVICE;
            `KIND_SELFTEST: sc_w = SELF_TEST_DRIVE ? `SC_SELFTEST_ON
                                                   : `SC_SELFTEST_OFF;
            `KIND_AUTOZERO: sc_w = `SC_AUTOZERO;
            `KIND_OTP:      sc_w = `SC_OTP;
            `KIND_ERROR:    sc_w = `SC_ERROR;
            // the reserved code has no source, never sent
            default:        sc_w = `SC_RUN;
        endcase
    end

    // 8-bit device data sits left justified in a 10-bit field
    assign device_field_w = (!DATA_WIDTH_SELECT && (mode_w != `MODE_10BIT))
                          ? {FRAME_DATA[`NARROW_W-1:0], 2'b00}
                          : FRAME_DATA;

    // error code replaces run-time sensor data
    // error frames carry the error type in the field
    assign run_field_w = cfg_err_w ? CONFIG_ERROR_CODE : FRAME_DATA;

    assign field_w = (FRAME_KIND == `KIND_DEVICE) ? device_field_w
                   : (FRAME_KIND == `KIND_RUN)    ? run_field_w
                   : FRAME_DATA;

    assign data_len_w  = DATA_WIDTH_SELECT ? `NARROW_LEN : `WIDE_LEN;
    assign field_ext_w = DATA_WIDTH_SELECT
                       ? {5'h00, field_w[`NARROW_W-1:0]}
                       : {3'h0, field_w};

    // state code present only while not disabled
    // code sits just above the data field
    assign sc_len_w     = STATE_CODE_DISABLE ? `RST_CNT : `SC_LEN;
    assign code_shift_w = STATE_CODE_DISABLE ? `RST_CONTENT
                        : DATA_WIDTH_SELECT  ? {2'b00, sc_w, 8'h00}
                        : {sc_w, 10'h000};
    assign content_w     = code_shift_w | field_ext_w;
    assign content_len_w = sc_len_w + data_len_w;

    // ************************************************************
    // crc engine
    // ************************************************************
    // one content bit per cycle, MSB first
    assign shift_w    = (state_q == frame_enc_pkg::ST_SHIFT);
    assign last_bit_w = shift_w && (cnt_q == `RST_CNT);

    // remainder cleared as each frame is taken
    crc3_serial #(
        .W     (`CRC_W),
        .TAPS  (`CRC_TAPS)
    ) u_crc (
        .clk   (MCLK),
        .rst   (RST),
        .clear (take_w),
        .shift (shift_w),
        .din   (content_q[cnt_q]),
        .rem   (crc_rem)
    );

    // parity over content gives an even count of ones
    assign parity_w = ^content_q;

    // check method latched with the request
    assign check_len_w = parity_mode_q ? `PAR_LEN : `CRC_LEN;
    assign frame_len_w = len_q + check_len_w;

    // crc in the three low bits
    assign frame_w = parity_mode_q
                   ? {2'b00, content_q, parity_w}
                   : {content_q, crc_rem};

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            frame_enc_pkg::ST_IDLE:  begin
                if (take_w) begin
                    state_d = frame_enc_pkg::ST_SHIFT;
                end
            end
            frame_enc_pkg::ST_SHIFT: begin
                if (last_bit_w) begin
                    state_d = frame_enc_pkg::ST_EMIT;
                end
            end
            frame_enc_pkg::ST_EMIT:  state_d = frame_enc_pkg::ST_IDLE;
            default:                 state_d = frame_enc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state_q <= frame_enc_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // settings are frozen per frame so a change mid-frame cannot
    // split the code, field and check between two configurations
    always_ff @(posedge MCLK) begin
        if (RST) begin
            content_q     <= `RST_CONTENT;
            len_q         <= `RST_LEN;
            sc_q          <= `SC_RUN;
            omit_sc_q     <= 1'b0;
            parity_mode_q <= 1'b0;
        end else if (take_w) begin
            content_q     <= content_w;
            len_q         <= {1'b0, content_len_w};
            sc_q          <= sc_w;
            omit_sc_q     <= STATE_CODE_DISABLE;
            parity_mode_q <= CHECK_METHOD_SELECT;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cnt_q <= `RST_CNT;
        end else if (take_w) begin
            cnt_q <= content_len_w - 4'h1;
        end else if (shift_w && !last_bit_w) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_ff @(posedge MCLK) begin
        if (RST) begin
            frame_q <= `RST_FRAME;
            valid_q <= 1'b0;
        end else begin
            valid_q <= (state_q == frame_enc_pkg::ST_EMIT);
            if (state_q == frame_enc_pkg::ST_EMIT) begin
                frame_q <= frame_w;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            FRAME_LEN <= `RST_LEN;
            STATE_CODE_BIT_HIGH <= 1'b0;
            STATE_CODE_BIT_MID  <= 1'b0;
            STATE_CODE_BIT_LOW  <= 1'b0;
        end else if (state_q == frame_enc_pkg::ST_EMIT) begin
            FRAME_LEN <= frame_len_w;
            // shows zero when the code was left out of the frame
            STATE_CODE_BIT_HIGH <= sc_q[2] && !omit_sc_q;
            STATE_CODE_BIT_MID  <= sc_q[1] && !omit_sc_q;
            STATE_CODE_BIT_LOW  <= sc_q[0] && !omit_sc_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            reject_q     <= 1'b0;
            busy_q       <= 1'b0;
            full_range_q <= 1'b0;
            cfg_err_q    <= 1'b0;
        end else begin
            reject_q     <= reject_w;
            busy_q       <= (state_d != frame_enc_pkg::ST_IDLE);
            full_range_q <= full_range_w;
            cfg_err_q    <= cfg_err_w;
        end
    end

    assign FRAME_VALID  = valid_q;
    assign FRAME_BITS   = frame_q;
    assign BUSY         = busy_q;
    assign REJECT       = reject_q;
    assign FULL_RANGE   = full_range_q;
    assign CONFIG_ERROR = cfg_err_q;

endmodule

// ### inc/fsvce_cfg.svh
/*
 * Constants of the frame tail encoder: state codes, request kinds,
 * field widths, check polynomial and reset values.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef FSVCE_CFG_SVH
`define FSVCE_CFG_SVH

// ****************************************************************
// field widths
// ****************************************************************
`define SC_W            3
`define DATA_W          10
`define NARROW_W        8
`define CONTENT_W       13
`define CNT_W           4
`define CRC_W           3
`define FRAME_W         16
`define LEN_W           5
`define KIND_W          3

// ****************************************************************
// state codes, request kinds and device data modes
// ****************************************************************
`define SC_RUN          3'h0
`define SC_DEVICE       3'h1
`define SC_SELFTEST_OFF 3'h2
`define SC_SELFTEST_ON  3'h3
`define SC_AUTOZERO     3'h4
`define SC_OTP          3'h5
`define SC_ERROR        3'h6
`define SC_RESERVED     3'h7
`define KIND_RUN        3'h0
`define KIND_DEVICE     3'h1
`define KIND_SELFTEST   3'h2
`define KIND_AUTOZERO   3'h3
`define KIND_OTP        3'h4
`define KIND_ERROR      3'h5
`define MODE_ALL        2'h0
`define MODE_10BIT      2'h3

// ****************************************************************
// check taps of x^3 + x + 1, lengths and reset values
// ****************************************************************
`define CRC_TAPS        3'h3
`define CRC_LEN         5'h03
`define PAR_LEN         5'h01
`define SC_LEN          4'h3
`define WIDE_LEN        4'hA
`define NARROW_LEN      4'h8
`define RST_CRC         3'h0
`define RST_FRAME       16'h0000
`define RST_LEN         5'h00
`define RST_CONTENT     13'h0000
`define RST_CNT         4'h0

`endif

// ### inc/frame_enc_pkg.sv
/*
 * Types shared by the frame tail encoder files.
 * Assumes fsvce_cfg.svh is on the include path.
 */
`include "fsvce_cfg.svh"

package frame_enc_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_EMIT
    } enc_state_e;

    typedef logic [`DATA_W-1:0]    data_t;
    typedef logic [`CONTENT_W-1:0] content_t;
    typedef logic [`FRAME_W-1:0]   frame_t;

endpackage

// ### hdl/crc3_serial.sv
/*
 * Serial CRC remainder register, one message bit per clock, MSB first.
 * Assumes the caller clears it before the first bit of each message.
 */
`timescale 1ns/100ps

module crc3_serial #(
    parameter int unsigned             W    = 3,
    parameter logic [W-1:0]            TAPS = 3'h3
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // control
    input  wire logic                  clear,
    input  wire logic                  shift,
    input  wire logic                  din,
    // remainder
    output logic [W-1:0]               rem
);

    logic [W-1:0] rem_q;
    logic [W-1:0] rem_d;
    logic         fb;

    // feeding at the top gives the remainder of msg * x^W directly,
    // so no trailing zero bits need to be clocked in
    assign fb    = rem_q[W-1] ^ din;
    assign rem_d = {rem_q[W-2:0], 1'b0} ^ (fb ? TAPS : '0);
    assign rem   = rem_q;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            rem_q <= '0;
        end else if (shift) begin
            rem_q <= rem_d;
        end
    end

endmodule

// ### test/frame_enc_checker.sv
/*
 * Port checker of the frame tail encoder.
 * Assumes it is bound onto the encoder top module by the bind below.
 */
`timescale 1ns/100ps
`include "fsvce_cfg.svh"

module frame_enc_checker (
    // clock and reset
    input wire logic                MCLK,
    input wire logic                RST,
    // configuration, status and request
    input wire logic                STATE_CODE_DISABLE,
    input wire logic                CHECK_METHOD_SELECT,
    input wire logic                DATA_WIDTH_SELECT,
    input wire logic                OFFSET_REMOVAL_ENABLE,
    input wire logic                DEVICE_DATA_MODE_HIGH,
    input wire logic                DEVICE_DATA_MODE_LOW,
    input wire logic                CONFIG_MODE,
    input wire logic                SELF_TEST_DRIVE,
    input wire logic                FRAME_REQ,
    input wire logic [`KIND_W-1:0]  FRAME_KIND,
    // outputs watched
    input wire logic                FRAME_VALID,
    input wire logic [`FRAME_W-1:0] FRAME_BITS,
    input wire logic [`LEN_W-1:0]   FRAME_LEN,
    input wire logic                STATE_CODE_BIT_HIGH,
    input wire logic                STATE_CODE_BIT_MID,
    input wire logic                STATE_CODE_BIT_LOW,
    input wire logic                BUSY,
    input wire logic                REJECT,
    input wire logic                FULL_RANGE,
    input wire logic                CONFIG_ERROR
);
    // ************************************************************
    // settings captured at the accepting edge
    // ************************************************************
    logic [1:0] mode;
    logic [2:0] code, exp_code, kind_q;
    logic [4:0] exp_len, exp_wait, wait_q;
    logic       take, refuse, scd_q, dat_q, cms_q, std_q, cerr_q;

    function automatic logic [2:0] rem_of(input logic [15:0] f,
                                          input logic [4:0] n);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 15; i >= 0; i--)
            if (i < n) r = {r[1:0], 1'b0} ^ ((r[2] ^ f[i]) ? 3'h3 : 3'h0);
        return r;
    endfunction

    assign mode = {DEVICE_DATA_MODE_HIGH, DEVICE_DATA_MODE_LOW};
    assign code = {STATE_CODE_BIT_HIGH, STATE_CODE_BIT_MID,
                   STATE_CODE_BIT_LOW};
    assign take = FRAME_REQ && !BUSY && FRAME_KIND <= `KIND_ERROR
                  && (FRAME_KIND != `KIND_OTP || CONFIG_MODE);
    assign refuse = FRAME_REQ && !take;
    // edges from acceptance to the sampled valid pulse: content plus 2
    assign exp_wait = (scd_q ? 5'h02 : 5'h05) + (dat_q ? 5'h08 : 5'h0A);
    assign exp_len = exp_wait - 5'h02 + (cms_q ? 5'h01 : 5'h03);
    assign exp_code = kind_q == `KIND_RUN ? (cerr_q ? `SC_ERROR : `SC_RUN)
        : kind_q == `KIND_DEVICE ? `SC_DEVICE
        : kind_q == `KIND_SELFTEST ? {2'h1, std_q}
        : kind_q == `KIND_AUTOZERO ? `SC_AUTOZERO
        : kind_q == `KIND_OTP ? `SC_OTP : `SC_ERROR;

    always_ff @(posedge MCLK) begin
        if (RST) wait_q <= 5'h00;
        else if (take) wait_q <= 5'h01;
        else if (FRAME_VALID) wait_q <= 5'h00;
        else if (wait_q != 5'h00) wait_q <= wait_q + 5'h01;
        if (take) begin
            {scd_q, dat_q, cms_q} <= {STATE_CODE_DISABLE,
                DATA_WIDTH_SELECT, CHECK_METHOD_SELECT};
            {kind_q, std_q} <= {FRAME_KIND, SELF_TEST_DRIVE};
            cerr_q <= (STATE_CODE_DISABLE && mode == 2'h0)
                      || (DATA_WIDTH_SELECT && mode == 2'h3);
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_take;
        take;
    endsequence
    sequence s_done;
        FRAME_VALID ##1 !FRAME_VALID;
    endsequence

    chk_busy_after: assert property (s_take |=> BUSY)
        else $error("busy not raised after accepted request");
    chk_frame_bound: assert property (s_take |-> ##[10:15] s_done)
        else $error("frame not finished in time");
    chk_frame_wait: assert property (FRAME_VALID |-> wait_q == exp_wait)
        else $error("frame latency off");
    chk_frame_length: assert property (FRAME_VALID |-> FRAME_LEN == exp_len)
        else $error("frame length off");
    chk_code_omitted: assert property (FRAME_VALID && scd_q |-> code == 3'h0)
        else $error("state code present while disabled");
    chk_code_table: assert property (FRAME_VALID && !scd_q |-> code == exp_code)
        else $error("state code does not match frame kind");
    chk_no_reserved: assert property (FRAME_VALID |-> code != `SC_RESERVED)
        else $error("reserved state code sent");
    chk_crc_zero: assert property (FRAME_VALID && !cms_q
        |-> rem_of(FRAME_BITS, FRAME_LEN) == 3'h0)
        else $error("frame does not divide by the check polynomial");
    chk_parity_even: assert property (FRAME_VALID && cms_q |-> !(^FRAME_BITS))
        else $error("frame parity odd");
    chk_reject_pulse: assert property (refuse |=> REJECT)
        else $error("refused request not flagged");
    chk_range_flag: assert property (!$past(RST) |-> FULL_RANGE
        == $past(!STATE_CODE_DISABLE && !OFFSET_REMOVAL_ENABLE))
        else $error("full range flag off");
    chk_config_error: assert property (!$past(RST) |-> CONFIG_ERROR
        == $past((STATE_CODE_DISABLE && mode == 2'h0)
                 || (DATA_WIDTH_SELECT && mode == 2'h3)))
        else $error("configuration error flag off");
endmodule

bind frame_state_vector_check_encoder frame_enc_checker frame_enc_checker_i (
    .MCLK(MCLK), .RST(RST), .STATE_CODE_DISABLE(STATE_CODE_DISABLE),
    .CHECK_METHOD_SELECT(CHECK_METHOD_SELECT),
    .DATA_WIDTH_SELECT(DATA_WIDTH_SELECT),
    .OFFSET_REMOVAL_ENABLE(OFFSET_REMOVAL_ENABLE),
    .DEVICE_DATA_MODE_HIGH(DEVICE_DATA_MODE_HIGH),
    .DEVICE_DATA_MODE_LOW(DEVICE_DATA_MODE_LOW),
    .CONFIG_MODE(CONFIG_MODE), .SELF_TEST_DRIVE(SELF_TEST_DRIVE),
    .FRAME_REQ(FRAME_REQ), .FRAME_KIND(FRAME_KIND),
    .FRAME_VALID(FRAME_VALID), .FRAME_BITS(FRAME_BITS),
    .FRAME_LEN(FRAME_LEN), .STATE_CODE_BIT_HIGH(STATE_CODE_BIT_HIGH),
    .STATE_CODE_BIT_MID(STATE_CODE_BIT_MID),
    .STATE_CODE_BIT_LOW(STATE_CODE_BIT_LOW), .BUSY(BUSY), .REJECT(REJECT),
    .FULL_RANGE(FULL_RANGE), .CONFIG_ERROR(CONFIG_ERROR));

// ### test/frame_receiver_model.sv
/*
 * Control module model: judges each finished frame as a receiver would.
 * Assumes frames are handed over as right-aligned words with a length.
 */
`timescale 1ns/100ps

module frame_receiver_model (
    // frame in
    input wire logic        clk,
    input wire logic        valid,
    input wire logic [15:0] bits,
    input wire logic [4:0]  len,
    input wire logic        parity_mode,
    // verdict on the last frame
    output logic            ok_q
);
    // ************************************************************
    // frame check
    // ************************************************************
    function automatic logic [2:0] rem_of(input logic [15:0] f,
                                          input logic [4:0] n);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 15; i >= 0; i--)
            if (i < n) r = {r[1:0], 1'b0} ^ ((r[2] ^ f[i]) ? 3'h3 : 3'h0);
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (valid) ok_q <= parity_mode ? !(^bits) : rem_of(bits, len) == 3'h0;
    end
endmodule

// ### test/frame_state_vector_check_encoder_test.sv
/*
 * Self-checking bench of the frame tail encoder with receiver model.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/100ps

module frame_state_vector_check_encoder_test;
    localparam logic [9:0] CERR = 10'h2C3;
    logic        mclk, rst, sc_off, chk_sel, width_sel, oz_en, cfg, st_drv;
    logic        req, valid, sch, scm, scl, busy, rej, full, cerr, ok;
    logic [1:0]  mode;
    logic [2:0]  kind, e_code;
    logic [9:0]  data;
    logic [15:0] bits, e_bits;
    logic [4:0]  len, e_len;
    int          miscompares, tests_run;

    frame_state_vector_check_encoder #(.CONFIG_ERROR_CODE(CERR))
        frame_state_vector_check_encoder_i (
        .MCLK(mclk), .RST(rst), .STATE_CODE_DISABLE(sc_off),
        .CHECK_METHOD_SELECT(chk_sel), .DATA_WIDTH_SELECT(width_sel),
        .OFFSET_REMOVAL_ENABLE(oz_en), .DEVICE_DATA_MODE_HIGH(mode[1]),
        .DEVICE_DATA_MODE_LOW(mode[0]), .CONFIG_MODE(cfg),
        .SELF_TEST_DRIVE(st_drv), .FRAME_REQ(req), .FRAME_KIND(kind),
        .FRAME_DATA(data), .FRAME_VALID(valid), .FRAME_BITS(bits),
        .FRAME_LEN(len), .STATE_CODE_BIT_HIGH(sch), .STATE_CODE_BIT_MID(scm),
        .STATE_CODE_BIT_LOW(scl), .BUSY(busy), .REJECT(rej),
        .FULL_RANGE(full), .CONFIG_ERROR(cerr));
    frame_receiver_model frame_receiver_model_i (.clk(mclk), .valid(valid),
        .bits(bits), .len(len), .parity_mode(chk_sel), .ok_q(ok));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic wrap_up();
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic setc(input logic s, c, w, z, input logic [1:0] m);
        @(posedge mclk);
        {sc_off, chk_sel, width_sel, oz_en, mode} <= {s, c, w, z, m};
    endtask
    // expected frame from the settings now on the inputs
    task automatic build(input logic [2:0] k, input logic [9:0] d);
        logic        ce;
        logic [2:0]  r;
        logic [4:0]  n;
        logic [15:0] ct;
        ce = (sc_off && mode == 2'h0) || (width_sel && mode == 2'h3);
        ct = {6'h00, (k == 3'h0 && ce) ? CERR : d};
        if (k == 3'h1 && !width_sel && mode != 2'h3) ct = {6'h00, d[7:0], 2'h0};
        if (width_sel) ct[15:8] = 8'h00;
        n = width_sel ? 5'h08 : 5'h0A;
        e_code = k == 3'h0 ? (ce ? 3'h6 : 3'h0) : k == 3'h2 ? {2'h1, st_drv}
            : k == 3'h3 ? 3'h4 : k == 3'h4 ? 3'h5 : k == 3'h5 ? 3'h6 : 3'h1;
        if (sc_off) e_code = 3'h0;
        else ct = ct | ({13'h0000, e_code} << n);
        if (!sc_off) n = n + 5'h03;
        r = 3'h0;
        for (int i = 15; i >= 0; i--)
            if (i < n) r = {r[1:0], 1'b0} ^ ((r[2] ^ ct[i]) ? 3'h3 : 3'h0);
        e_bits = chk_sel ? {ct[14:0], ^ct} : {ct[12:0], r};
        e_len = n + (chk_sel ? 5'h01 : 5'h03);
    endtask
    task automatic poke(input logic [2:0] k, input logic e);
        @(posedge mclk);
        {req, kind, data} <= {1'b1, k, 10'h155};
        @(posedge mclk);
        req <= 1'b0;
        #1 chk("reject", {15'h0000, e}, {15'h0000, rej});
    endtask
    task automatic finish_frame();
        int i;
        for (i = 0; i < 40 && valid !== 1'b1; i++) @(posedge mclk) #1;
        if (i == 40) begin
            chk("frame valid", 16'h0001, 16'h0000);
            wrap_up();
        end
        chk("frame bits", e_bits, bits);
        chk("frame length", {11'h000, e_len}, {11'h000, len});
        chk("state code", {13'h0000, e_code}, {13'h0000, sch, scm, scl});
        @(posedge mclk) #1 chk("receiver verdict", 16'h0001, {15'h0000, ok});
    endtask
    task automatic send(input logic [2:0] k, input logic [9:0] d);
        @(posedge mclk);
        build(k, d);
        {req, kind, data} <= {1'b1, k, d};
        @(posedge mclk);
        req <= 1'b0;
        finish_frame();
    endtask

    task automatic t_codes();
        setc(1'b0, 1'b0, 1'b0, 1'b0, 2'h1);
        for (int k = 0; k < 6; k++) send(3'(k), 10'h2A5 ^ 10'(k));
        st_drv <= 1'b1;
        send(3'h2, 10'h3C1);
        setc(1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
        send(3'h1, 10'h2F7);
    endtask
    task automatic t_parity();
        setc(1'b1, 1'b1, 1'b1, 1'b0, 2'h1);
        send(3'h0, 10'h0B6);
        send(3'h3, 10'h049);
        setc(1'b0, 1'b1, 1'b0, 1'b1, 2'h2);
        send(3'h1, 10'h1E3);
        send(3'h5, 10'h3FF);
    endtask
    task automatic t_refuse();
        setc(1'b0, 1'b0, 1'b1, 1'b0, 2'h2);
        cfg <= 1'b0;
        poke(3'h4, 1'b1);
        poke(3'h6, 1'b1);
        poke(3'h7, 1'b1);
        poke(3'h0, 1'b0);
        build(3'h0, 10'h155);
        poke(3'h0, 1'b1);
        finish_frame();
        cfg <= 1'b1;
    endtask
    task automatic t_range();
        for (int i = 0; i < 4; i++) begin
            setc(i[1], 1'b0, 1'b0, i[0], 2'h0);
            @(posedge mclk) #1 chk("full range", {15'h0000, i == 0},
                                   {15'h0000, full});
        end
        setc(1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
        send(3'h0, 10'h3FF);
        setc(1'b0, 1'b0, 1'b1, 1'b0, 2'h3);
        send(3'h0, 10'h0AA);
        chk("config error", 16'h0001, {15'h0000, cerr});
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst, sc_off, chk_sel, width_sel, oz_en, mode} = {6'h20, 1'b0};
        {cfg, st_drv, req, kind, data} = {2'h2, 1'b0, 13'h0000};
        {miscompares, tests_run} = {32'h0, 32'h0};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("busy after reset", 16'h0000, {15'h0000, busy});
        t_codes();
        t_parity();
        t_refuse();
        t_range();
        wrap_up();
    end
endmodule
